// [hdl/host_port_pkg.sv]
// Constants shared by the card bus host port files
package host_port_pkg;
    localparam int          STRAP_W       = 7;
    localparam int          STRAP_SEL0    = 0;
    localparam int          STRAP_SEL1    = 1;
    localparam int          STRAP_SEL2    = 2;
    localparam int          STRAP_RSVD    = 3;
    localparam int          STRAP_SEL4    = 4;
    localparam int          STRAP_WAITPOL = 5;
    localparam int          STRAP_CLKDIV  = 6;
    localparam logic [6:0]  STRAP_RST     = 7'h00;
    localparam logic [3:0]  SEL_SEP_LE    = 4'h4;
    localparam logic        RSVD_LEVEL    = 1'b1;
    localparam int          ADDR_W        = 18;
    localparam int          DATA_W        = 16;
    localparam logic [17:0] BUF_BYTES     = 18'h28000;
    localparam logic [1:0]  BE_WORD       = 2'h3;
    localparam logic [1:0]  BE_LOW        = 2'h1;
    localparam logic [1:0]  BE_HIGH       = 2'h2;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_REQ  = 2'b01,
        ST_DONE = 2'b10
    } port_state_t;
endpackage

// [hdl/strap_latch.sv]
// Configuration strap capture at reset release
`timescale 1ns/1ps
module strap_latch (
    input  wire logic       i_clk,
    input  wire logic       i_rstn,
    input  wire logic [6:0] i_straps,
    output logic      [6:0] o_straps,
    output logic            o_captured
);
    logic [6:0] straps_r;
    logic [6:0] straps_nxt;
    logic       cap_r;
    logic       cap_nxt;

    always_comb begin
        straps_nxt = straps_r;
        cap_nxt    = 1'b1;
        if (!cap_r) begin
            straps_nxt = i_straps;
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            straps_r <= host_port_pkg::STRAP_RST;
            cap_r    <= 1'b0;
        end else begin
            straps_r <= straps_nxt;
            cap_r    <= cap_nxt;
        end
    end

    assign o_straps   = straps_r;
    assign o_captured = cap_r;

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rstn);

    strap_hold_a: assert property (cap_r |=> $stable(straps_r))
        else $error("Strap values changed after capture");
endmodule // strap_latch

// [hdl/host_port_top.sv]
// Card bus separate-strobe host port of the display controller
// How it works
// - Seven straps latched at reset release
// - Pattern 0100 selects separate-strobe little endian
// - Strap five sets wait output polarity
// - Strap six divides host clock by two
// - Address bit 18 picks registers or buffer
// - Only bits 18..0 decode, 512K aliasing
// - Wait held until data valid or accepted
// - High byte enable with bit 0 steers lanes
`timescale 1ns/1ps
module host_port_top (
    input  wire logic        I_CLK_SYS,
    input  wire logic        I_RSTN,
    input  wire logic        I_STRAP_HOST_SEL_HI,
    input  wire logic [2:0]  I_STRAP_HOST_SEL_LO,
    input  wire logic        I_STRAP_RESERVED,
    input  wire logic        I_STRAP_WAIT_POLARITY,
    input  wire logic        I_STRAP_CLOCK_DIVIDE,
    input  wire logic        I_CHIP_SEL_N,
    input  wire logic        I_MEM_REG_SEL,
    input  wire logic [17:0] I_HOST_ADDR_IN,
    input  wire logic        I_READ_STROBE_N,
    input  wire logic        I_LOW_WRITE_ENABLE_N,
    input  wire logic        I_HIGH_BYTE_ENABLE_N,
    input  wire logic [15:0] I_HOST_DATA_BUS,
    output logic      [15:0] O_HOST_DATA_BUS,
    output logic             O_HOST_DATA_BUS_OE,
    output logic             O_WAIT,
    output logic             O_MODE_OK,
    output logic             O_BUS_TICK,
    output logic             O_MEM_REQ,
    output logic             O_MEM_WE,
    output logic             O_MEM_SEL_BUF,
    output logic      [17:0] O_MEM_ADDR,
    output logic      [1:0]  O_MEM_BE,
    output logic      [15:0] O_MEM_WDATA,
    input  wire logic        I_MEM_ACK,
    input  wire logic [15:0] I_MEM_RDATA
);
    ////////////////////////////////////////////////////////////////////////
    // Strap capture and decode
    logic [6:0] straps;
    logic       captured;
    logic [3:0] host_sel;
    logic       wait_pol;
    logic       clk_div;

    strap_latch u_straps (
        .i_clk      (I_CLK_SYS),
        .i_rstn     (I_RSTN),
        .i_straps   ({I_STRAP_CLOCK_DIVIDE, I_STRAP_WAIT_POLARITY,
                      I_STRAP_HOST_SEL_HI, I_STRAP_RESERVED,
                      I_STRAP_HOST_SEL_LO}),
        .o_straps   (straps),
        .o_captured (captured)
    );

    assign host_sel  = {straps[host_port_pkg::STRAP_SEL4],
                        straps[host_port_pkg::STRAP_SEL2],
                        straps[host_port_pkg::STRAP_SEL1],
                        straps[host_port_pkg::STRAP_SEL0]};
    assign wait_pol  = straps[host_port_pkg::STRAP_WAITPOL];
    assign clk_div   = straps[host_port_pkg::STRAP_CLKDIV];
    assign O_MODE_OK = captured
        && (host_sel == host_port_pkg::SEL_SEP_LE)
        && (straps[host_port_pkg::STRAP_RSVD]
            == host_port_pkg::RSVD_LEVEL);

    ////////////////////////////////////////////////////////////////////////
    // Bus clock phase
    logic phase_r;
    logic phase_nxt;

    always_comb begin
        phase_nxt = clk_div ? !phase_r : 1'b0;
    end

    always_ff @(posedge I_CLK_SYS or negedge I_RSTN) begin
        if (!I_RSTN) begin
            phase_r <= 1'b0;
        end else begin
            phase_r <= phase_nxt;
        end
    end

    assign O_BUS_TICK = !clk_div || phase_r;

    ////////////////////////////////////////////////////////////////////////
    // Access sequencer
    host_port_pkg::port_state_t state_r;
    host_port_pkg::port_state_t state_nxt;
    logic        rd_act;
    logic        wr_act;
    logic        access;
    logic        we_r;
    logic        we_nxt;
    logic        sel_r;
    logic        sel_nxt;
    logic [17:0] addr_r;
    logic [17:0] addr_nxt;
    logic [1:0]  be_r;
    logic [1:0]  be_nxt;
    logic [1:0]  be_in;
    logic [15:0] wdata_r;
    logic [15:0] wdata_nxt;
    logic [15:0] rdata_r;
    logic [15:0] rdata_nxt;
    logic        in_range;
    logic        wait_act;

    assign rd_act = !I_CHIP_SEL_N && !I_READ_STROBE_N;
    assign wr_act = !I_CHIP_SEL_N && !I_LOW_WRITE_ENABLE_N;
    assign access = O_MODE_OK && (rd_act || wr_act);

    always_comb begin
        if (!I_HIGH_BYTE_ENABLE_N) begin
            be_in = host_port_pkg::BE_WORD;
        end else if (I_HOST_ADDR_IN[0]) begin
            be_in = host_port_pkg::BE_HIGH;
        end else begin
            be_in = host_port_pkg::BE_LOW;
        end
    end

    assign in_range = !sel_r || (addr_r < host_port_pkg::BUF_BYTES);

    always_comb begin
        state_nxt = state_r;
        we_nxt    = we_r;
        sel_nxt   = sel_r;
        addr_nxt  = addr_r;
        be_nxt    = be_r;
        wdata_nxt = wdata_r;
        rdata_nxt = rdata_r;
        case (state_r)
            host_port_pkg::ST_IDLE: begin
                if (access && O_BUS_TICK) begin
                    state_nxt = host_port_pkg::ST_REQ;
                    we_nxt    = wr_act;
                    sel_nxt   = I_MEM_REG_SEL;
                    addr_nxt  = I_HOST_ADDR_IN;
                    be_nxt    = be_in;
                    wdata_nxt = I_HOST_DATA_BUS;
                    if (I_HIGH_BYTE_ENABLE_N && I_HOST_ADDR_IN[0]) begin
                        wdata_nxt = {I_HOST_DATA_BUS[7:0], 8'h00};
                    end
                end
            end
            host_port_pkg::ST_REQ: begin
                if (I_MEM_ACK || !in_range) begin
                    state_nxt = host_port_pkg::ST_DONE;
                    rdata_nxt = in_range ? I_MEM_RDATA : 16'h0000;
                    if (be_r == host_port_pkg::BE_HIGH) begin
                        rdata_nxt = {8'h00, rdata_nxt[15:8]};
                    end
                end
            end
            host_port_pkg::ST_DONE: begin
                if (!access) begin
                    state_nxt = host_port_pkg::ST_IDLE;
                end
            end
            default: begin
                state_nxt = host_port_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge I_CLK_SYS or negedge I_RSTN) begin
        if (!I_RSTN) begin
            state_r <= host_port_pkg::ST_IDLE;
            we_r    <= 1'b0;
            sel_r   <= 1'b0;
            addr_r  <= 18'h00000;
            be_r    <= 2'h0;
            wdata_r <= 16'h0000;
            rdata_r <= 16'h0000;
        end else begin
            state_r <= state_nxt;
            we_r    <= we_nxt;
            sel_r   <= sel_nxt;
            addr_r  <= addr_nxt;
            be_r    <= be_nxt;
            wdata_r <= wdata_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs
    assign wait_act = access && (state_r != host_port_pkg::ST_DONE);
    assign O_WAIT   = wait_pol ? wait_act : !wait_act;

    assign O_MEM_REQ     = (state_r == host_port_pkg::ST_REQ) && in_range;
    assign O_MEM_WE      = we_r;
    assign O_MEM_SEL_BUF = sel_r;
    assign O_MEM_ADDR    = addr_r;
    assign O_MEM_BE      = be_r;
    assign O_MEM_WDATA   = wdata_r;

    assign O_HOST_DATA_BUS    = rdata_r;
    assign O_HOST_DATA_BUS_OE = O_MODE_OK && rd_act;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge I_CLK_SYS); endclocking
    default disable iff (!I_RSTN);

    sequence seq_start;
        (state_r == host_port_pkg::ST_IDLE) && access && O_BUS_TICK;
    endsequence

    sequence seq_finish;
        (state_r == host_port_pkg::ST_REQ) && I_MEM_ACK && access;
    endsequence

    mode_select_a: assert property (O_MODE_OK |-> host_sel == 4'h4)
        else $error("Port enabled with wrong select straps");
    wait_polarity_a: assert property (
        (access && state_r == host_port_pkg::ST_REQ)
        |-> O_WAIT == wait_pol)
        else $error("Wait level does not follow polarity strap");
    clock_half_a: assert property (
        (captured && clk_div && O_BUS_TICK) |=> !O_BUS_TICK)
        else $error("Divided bus tick came two cycles running");
    clock_full_a: assert property (
        (captured && !clk_div && state_r == host_port_pkg::ST_IDLE && access)
        |=> state_r == host_port_pkg::ST_REQ)
        else $error("Undivided access did not start at once");
    space_select_a: assert property (
        seq_start |=> O_MEM_SEL_BUF == $past(I_MEM_REG_SEL))
        else $error("Space select not taken from address bit 18");
    addr_alias_a: assert property (
        seq_start |=> O_MEM_ADDR == $past(I_HOST_ADDR_IN))
        else $error("Address not taken from low address bits");
    wait_release_a: assert property (
        seq_finish |=> !wait_act ##0 O_HOST_DATA_BUS == $past(
        (be_r == 2'h2) ? {8'h00, I_MEM_RDATA[15:8]} : I_MEM_RDATA))
        else $error("Wait not released with data after answer");
    wait_hold_a: assert property (seq_start |=> wait_act)
        else $error("Wait dropped before the access completed");
    byte_lane_a: assert property (
        seq_start ##0 !I_HIGH_BYTE_ENABLE_N |=> O_MEM_BE == 2'h3)
        else $error("High byte enable did not give a word access");
endmodule // host_port_top

// [tb/mem_model.sv]
// Behavioural model of the internal memory arbiter behind the host port
`timescale 1ns/1ps
module mem_model (
    input  wire logic        i_clk,
    input  wire logic        i_rstn,
    input  wire logic        i_req,
    input  wire logic        i_we,
    input  wire logic        i_sel_buf,
    input  wire logic [17:0] i_addr,
    input  wire logic [1:0]  i_be,
    input  wire logic [15:0] i_wdata,
    input  wire logic [3:0]  i_delay,
    output logic             o_ack,
    output logic      [15:0] o_rdata
);
    logic [15:0] mem [0:255];
    logic [3:0]  cnt;
    logic [7:0]  idx;
    assign idx = {i_sel_buf, i_addr[7:1]};
    ////////////////////////////////////////////////////////////////////////
    // Grant after a set arbitration delay; data scrambled outside the grant
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            cnt     <= 4'h0;
            o_ack   <= 1'b0;
            o_rdata <= 16'h0000;
        end else if (i_req && !o_ack && cnt == i_delay) begin
            o_ack   <= 1'b1;
            o_rdata <= mem[idx];
            if (i_we && i_be[0]) mem[idx][7:0] <= i_wdata[7:0];
            if (i_we && i_be[1]) mem[idx][15:8] <= i_wdata[15:8];
            cnt     <= 4'h0;
        end else begin
            o_ack   <= 1'b0;
            o_rdata <= ~o_rdata;
            cnt     <= i_req ? cnt + 4'h1 : 4'h0;
        end
    end
endmodule // mem_model

// [tb/host_port_top_tb.sv]
// Self-checking bench for the card bus host port
`timescale 1ns/1ps
module host_port_top_tb;
    logic        clk = 1'b0, rstn = 1'b0, shi = 1'b0, rsv = 1'b1;
    logic        pol = 1'b0, div = 1'b0, cs_n = 1'b1, a18 = 1'b0;
    logic        rd_n = 1'b1, we_n = 1'b1, hb_n = 1'b1, oe_seen, t0;
    logic [2:0]  slo = 3'h4;
    logic [17:0] addr = 18'h00000;
    logic [15:0] drv = 16'h0000, q;
    logic [3:0]  dly = 4'h0;
    wire  [15:0] dout, mrd, mwd, bus;
    wire  [17:0] maddr;
    wire  [1:0]  mbe;
    wire         oe, wt, mok, tick, mreq, mwe, msel, mack;
    int          error_cnt = 0, n_compared = 0, nw;
    assign bus = oe ? dout : drv;
    always #2.5 clk = ~clk;
    ////////////////////////////////////////////////////////////////////////
    host_port_top DUT (
        .I_CLK_SYS(clk), .I_RSTN(rstn), .I_STRAP_HOST_SEL_HI(shi),
        .I_STRAP_HOST_SEL_LO(slo), .I_STRAP_RESERVED(rsv),
        .I_STRAP_WAIT_POLARITY(pol), .I_STRAP_CLOCK_DIVIDE(div),
        .I_CHIP_SEL_N(cs_n), .I_MEM_REG_SEL(a18), .I_HOST_ADDR_IN(addr),
        .I_READ_STROBE_N(rd_n), .I_LOW_WRITE_ENABLE_N(we_n),
        .I_HIGH_BYTE_ENABLE_N(hb_n), .I_HOST_DATA_BUS(bus),
        .O_HOST_DATA_BUS(dout), .O_HOST_DATA_BUS_OE(oe), .O_WAIT(wt),
        .O_MODE_OK(mok), .O_BUS_TICK(tick), .O_MEM_REQ(mreq),
        .O_MEM_WE(mwe), .O_MEM_SEL_BUF(msel), .O_MEM_ADDR(maddr),
        .O_MEM_BE(mbe), .O_MEM_WDATA(mwd), .I_MEM_ACK(mack),
        .I_MEM_RDATA(mrd));
    mem_model u_mem (
        .i_clk(clk), .i_rstn(rstn), .i_req(mreq), .i_we(mwe),
        .i_sel_buf(msel), .i_addr(maddr), .i_be(mbe), .i_wdata(mwd),
        .i_delay(dly), .o_ack(mack), .o_rdata(mrd));
    ////////////////////////////////////////////////////////////////////////
    task automatic check(input string nm, input logic [15:0] seen, exp);
        n_compared++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic reset_dut(input logic [6:0] s);
        @(negedge clk);
        rstn = 1'b0;
        {div, pol, shi, rsv, slo} = s;
        repeat (2) @(negedge clk);
        rstn = 1'b1;
        repeat (2) @(negedge clk);
    endtask
    task automatic acc(input logic we, sb, hb, input logic [17:0] a,
                       input logic [15:0] d);
        @(negedge clk);
        cs_n = 1'b0;
        a18 = sb;
        addr = a;
        hb_n = hb;
        drv = d;
        if (we) begin
            we_n = 1'b0;
        end else begin
            rd_n = 1'b0;
        end
        @(negedge clk);
        oe_seen = oe;
        nw = 0;
        while (wt !== ~pol && nw < 40) begin
            @(negedge clk);
            nw++;
        end
        check("wait_end", 16'(nw < 40), 16'h0001);
        q = bus;
        @(negedge clk);
        {cs_n, rd_n, we_n, hb_n} = 4'hf;
        drv = ~drv;
    endtask
    task automatic conclude;
        $display("Compared %0d, mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        #100000;
        error_cnt++;
        conclude;
    end
    initial begin
        reset_dut(7'h0c);
        check("mode_ok", 16'(mok), 16'h0001);
        check("wait_idle", 16'(wt), 16'h0001);
        check("tick_full", 16'(tick), 16'h0001);
        acc(1'b1, 1'b0, 1'b0, 18'h00010, 16'h1234);
        acc(1'b1, 1'b1, 1'b0, 18'h00010, 16'habcd);
        acc(1'b0, 1'b0, 1'b0, 18'h00010, 16'h0000);
        check("reg_word", q, 16'h1234);
        check("read_oe", 16'(oe_seen), 16'h0001);
        acc(1'b0, 1'b1, 1'b0, 18'h00010, 16'h0000);
        check("buf_word", q, 16'habcd);
        acc(1'b1, 1'b0, 1'b1, 18'h00010, 16'h00ee);
        acc(1'b1, 1'b0, 1'b1, 18'h00011, 16'h0077);
        acc(1'b0, 1'b0, 1'b0, 18'h00010, 16'h0000);
        check("byte_lanes", q, 16'h77ee);
        acc(1'b0, 1'b0, 1'b1, 18'h00011, 16'h0000);
        check("odd_byte", q, 16'h0077);
        acc(1'b1, 1'b1, 1'b0, 18'h28000, 16'h5555);
        acc(1'b0, 1'b1, 1'b0, 18'h28000, 16'h0000);
        check("out_range", q, 16'h0000);
        dly = 4'h6;
        {div, pol, shi, rsv, slo} = 7'h15;
        acc(1'b0, 1'b0, 1'b0, 18'h00010, 16'h0000);
        check("slow_wait", 16'(nw >= 6), 16'h0001);
        check("slow_data", q, 16'h77ee);
        check("strap_hold", 16'(mok), 16'h0001);
        dly = 4'h0;
        reset_dut(7'h6c);
        check("wait_hi_idle", 16'(wt), 16'h0000);
        t0 = tick;
        @(negedge clk);
        check("tick_half", 16'(tick), 16'(!t0));
        acc(1'b0, 1'b1, 1'b0, 18'h00010, 16'h0000);
        check("buf_div", q, 16'habcd);
        reset_dut(7'h04);
        check("rsvd_off", 16'(mok), 16'h0000);
        acc(1'b0, 1'b0, 1'b0, 18'h00010, 16'h0000);
        check("refused_oe", 16'(oe_seen), 16'h0000);
        reset_dut(7'h0d);
        check("sel_off", 16'(mok), 16'h0000);
        conclude;
    end
endmodule // host_port_top_tb
